// ===== design/cyclic_sched_pkg.sv
package cyclic_sched_pkg;

    // ==========================================================
    // register map (byte addresses, one word each)
    // ==========================================================
    localparam logic [11:0] conv_ctrl_off   = 12'h000;
    localparam logic [11:0] sched_stat_off  = 12'h004;
    localparam logic [11:0] step_period_off = 12'h008;

    // ==========================================================
    // conversion control fields
    // ==========================================================
    localparam int run_en_bit     = 0;  // cyclic_run_enable
    localparam int cont_bit       = 1;  // back-to-back mode
    localparam int wb_bit         = 2;  // cycle result writeback
    localparam int filt_lsb       = 3;  // acquisition filter [5:3]
    localparam int filt_w         = 3;
    localparam int bal_tim_bit    = 6;  // balance_timer_auto_hold
    localparam int bal_hold_bit   = 7;  // balance_auto_hold
    localparam int period_lsb     = 8;  // period code [11:8]
    localparam int period_w       = 4;
    localparam int ctrl_w         = 12;
    localparam logic [11:0] ctrl_rst = 12'h000;

    // ==========================================================
    // status fields
    // ==========================================================
    localparam int stat_active_bit = 0;  // routine active flag
    localparam int stat_ovr_bit    = 1;  // override_latch, w1c
    localparam int stat_lock_bit   = 2;  // locked after override
    localparam int stat_cnt_lsb    = 8;  // cycle_counter [15:8]

    // ==========================================================
    // routine shape and timing
    // ==========================================================
    localparam int num_steps = 4;
    localparam int per_w     = 4;       // step_periodicity width
    localparam int cnt_w     = 8;       // cycle_counter width
    localparam int tmr_w     = 16;      // cycle_period_timer width
    localparam logic [15:0] per_rst = 16'h0000;
    localparam int clk_period_ns    = 40;
    localparam int step_base_ns     = 4000;
    localparam int step_base_cycles =
        (step_base_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int period_unit_us   = 100;
    localparam int period_unit_cycles =
        (period_unit_us * 1000) / clk_period_ns;

    // scheduler states
    typedef enum logic [1:0] {
        st_off,
        st_active,
        st_idle,
        st_locked
    } sched_state_e;

endpackage

// ===== design/cyclic_conversion_scheduler.sv
`timescale 1ns/1ns
`default_nettype none

// Operation
// - run enable set starts cyclic routine
// - filter setting sets each step duration
// - writeback off: results only compared, discarded
// - writeback on: registers written each step that runs
// - period code programs cycle timer period
// - timer expiry: counter plus one, restart
// - step runs only if periodicity matches
// - counter frozen while timer counts in phases
// - enable rise: timer zeroed, counter kept
// - periodic disable waits for active end
// - continuous disable waits for pass end
// - active flag high only while steps run
// - overrun of period behaves back to back
// - mode bit picks periodic or continuous
// - continuous: restart and count per pass
// - mode bit ignored while disabled
// - enable sampled in idle or pass end
// - configuration sampled once per cycle, period code read live
// - override latch blocks restart, masks enable
module cyclic_conversion_scheduler (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [11:0]                           paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  override_req,
    output logic                                       routine_active,
    output logic      [1:0]                            step_index,
    output logic                                       step_done,
    output logic                                       compare_strobe,
    output logic                                       result_write,
    output logic      [cyclic_sched_pkg::filt_w-1:0]   step_filter,
    output logic                                       bal_timer_hold,
    output logic                                       bal_hold
);

    // ==========================================================
    // register file
    // ==========================================================
    logic [cyclic_sched_pkg::ctrl_w-1:0] ctrl_q;     // control word
    logic [15:0]                         per_q;      // periodicities
    logic                                ovr_q;      // override latch
    logic [31:0]                         prdata_q;   // read data
    logic                                slverr_q;   // unmapped flag
    logic                                setup;      // apb setup phase
    logic                                wr_acc;     // write accepted
    logic                                map_hit;    // address decodes

    cyclic_sched_pkg::sched_state_e state_q;        // scheduler state
    cyclic_sched_pkg::sched_state_e state_d;
    logic [cyclic_sched_pkg::cnt_w-1:0]  cnt_q;      // cycle_counter
    logic [cyclic_sched_pkg::tmr_w-1:0]  tmr_q;      // cycle_period_timer
    logic                                pend_q;     // expiry in active

    assign setup   = psel & ~penable;
    assign wr_acc  = psel & penable & pwrite;
    assign map_hit = (paddr == cyclic_sched_pkg::conv_ctrl_off)
                   | (paddr == cyclic_sched_pkg::sched_stat_off)
                   | (paddr == cyclic_sched_pkg::step_period_off);

    // zero wait state: read data is latched in the setup phase
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q;

    // read mux latched at setup so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            slverr_q <= ~map_hit;
            prdata_q <= 32'h0000_0000;
            if (paddr == cyclic_sched_pkg::conv_ctrl_off) begin
                prdata_q <= {20'h0_0000, ctrl_q};
            end else if (paddr == cyclic_sched_pkg::sched_stat_off) begin
                prdata_q[cyclic_sched_pkg::stat_active_bit] <=
                    (state_q == cyclic_sched_pkg::st_active);
                prdata_q[cyclic_sched_pkg::stat_ovr_bit]    <= ovr_q;
                prdata_q[cyclic_sched_pkg::stat_lock_bit]   <=
                    (state_q == cyclic_sched_pkg::st_locked);
                prdata_q[cyclic_sched_pkg::stat_cnt_lsb +:
                         cyclic_sched_pkg::cnt_w] <= cnt_q;
            end else if (paddr == cyclic_sched_pkg::step_period_off) begin
                prdata_q <= {16'h0000, per_q};
            end
        end
    end

    // software writable words, taken in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= cyclic_sched_pkg::ctrl_rst;
            per_q  <= cyclic_sched_pkg::per_rst;
        end else if (wr_acc) begin
            if (paddr == cyclic_sched_pkg::conv_ctrl_off) begin
                ctrl_q <= pwdata[cyclic_sched_pkg::ctrl_w-1:0];
            end
            if (paddr == cyclic_sched_pkg::step_period_off) begin
                per_q <= pwdata[15:0];
            end
        end
    end

    // ==========================================================
    // override latch
    // ==========================================================
    logic ovr_clr;  // write one to clear
    assign ovr_clr = wr_acc
                   & (paddr == cyclic_sched_pkg::sched_stat_off)
                   & pwdata[cyclic_sched_pkg::stat_ovr_bit];

    // a fault in the same cycle as the clear keeps the latch set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_q <= 1'b0;
        end else if (override_req
                     && state_q == cyclic_sched_pkg::st_active) begin
            ovr_q <= 1'b1;
        end else if (ovr_clr) begin
            ovr_q <= 1'b0;
        end
    end

    // ==========================================================
    // sampled configuration
    // ==========================================================
    logic                                 run_en;    // live enable
    logic                                 sample;    // take snapshot
    logic                                 cont_s;    // mode snapshot
    logic                                 wb_s;      // writeback snap
    logic [cyclic_sched_pkg::filt_w-1:0]  filt_s;    // filter snap
    logic                                 bal_tim_s; // hold snapshots
    logic                                 bal_s;
    logic [15:0]                          per_s;     // periodicity snap

    assign run_en = ctrl_q[cyclic_sched_pkg::run_en_bit];

    // snapshot only at routine start, so edits mid-pass wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cont_s    <= 1'b0;
            wb_s      <= 1'b0;
            filt_s    <= '0;
            bal_tim_s <= 1'b0;
            bal_s     <= 1'b0;
            per_s     <= cyclic_sched_pkg::per_rst;
        end else if (sample) begin
            cont_s    <= ctrl_q[cyclic_sched_pkg::cont_bit];
            wb_s      <= ctrl_q[cyclic_sched_pkg::wb_bit];
            filt_s    <= ctrl_q[cyclic_sched_pkg::filt_lsb +:
                                cyclic_sched_pkg::filt_w];
            bal_tim_s <= ctrl_q[cyclic_sched_pkg::bal_tim_bit];
            bal_s     <= ctrl_q[cyclic_sched_pkg::bal_hold_bit];
            per_s     <= per_q;
        end
    end

    // ==========================================================
    // cycle period timer
    // ==========================================================
    logic [cyclic_sched_pkg::period_w-1:0] pcode;    // period code
    logic [cyclic_sched_pkg::tmr_w-1:0]    plen;     // period in ticks
    logic                                  expiry;   // last tick
    logic                                  tmr_clr;  // fsm restart
    logic                                  tmr_run;  // timer counting

    assign pcode   = ctrl_q[cyclic_sched_pkg::period_lsb +:
                            cyclic_sched_pkg::period_w];
    // (code + 1) units; a wider code would need a wider timer
    assign plen    = 16'((16'(pcode) + 16'h0001)
                   * 16'(cyclic_sched_pkg::period_unit_cycles));
    assign tmr_run = ((state_q == cyclic_sched_pkg::st_active)
                   | (state_q == cyclic_sched_pkg::st_idle)) & ~cont_s;
    assign expiry  = tmr_run & (tmr_q == plen - 16'h0001);

    // continuous mode leaves the timer parked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_q <= '0;
        end else if (tmr_clr || expiry) begin
            tmr_q <= '0;
        end else if (tmr_run) begin
            tmr_q <= tmr_q + 16'h0001;
        end
    end

    // ==========================================================
    // routine step engine
    // ==========================================================
    logic                         start;     // restart from step 0
    logic [1:0]                   idx_q;     // current step
    logic [15:0]                  scnt_q;    // ticks in this step
    logic [15:0]                  slen;      // step length
    logic                         srun;      // current step enabled
    logic                         send;      // current step over
    logic                         done;      // pass complete
    logic [cyclic_sched_pkg::per_w-1:0] cur_per;

    // a step runs when its periodicity divides the counter
    function automatic logic step_due(
        input logic [cyclic_sched_pkg::per_w-1:0] per,
        input logic [cyclic_sched_pkg::cnt_w-1:0] cnt
    );
        logic [cyclic_sched_pkg::cnt_w-1:0] wide;
        wide = {4'h0, per};
        return (per != '0) && ((cnt % wide) == '0);
    endfunction

    assign cur_per = per_s[idx_q * cyclic_sched_pkg::per_w +:
                           cyclic_sched_pkg::per_w];
    assign srun = step_due(cur_per, cnt_q);
    assign slen = 16'(cyclic_sched_pkg::step_base_cycles) << filt_s;
    // skipped steps cost one tick so the walk stays simple
    assign send = (state_q == cyclic_sched_pkg::st_active)
                & (~srun | (scnt_q == slen - 16'h0001));
    assign done = send & (idx_q == 2'(cyclic_sched_pkg::num_steps - 1));

    // walk the fixed step order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_q  <= 2'b00;
            scnt_q <= 16'h0000;
        end else if (start) begin
            idx_q  <= 2'b00;
            scnt_q <= 16'h0000;
        end else if (send) begin
            idx_q  <= idx_q + 2'b01;
            scnt_q <= 16'h0000;
        end else if (state_q == cyclic_sched_pkg::st_active) begin
            scnt_q <= scnt_q + 16'h0001;
        end
    end

    // ==========================================================
    // scheduler state machine
    // ==========================================================
    logic cnt_inc;   // advance cycle_counter
    logic cnt_clr;   // stop and reset counters

    always_comb begin
        state_d = state_q;
        start   = 1'b0;
        sample  = 1'b0;
        tmr_clr = 1'b0;
        cnt_inc = 1'b0;
        cnt_clr = 1'b0;
        case (state_q)
            // enable rise: counter kept, timer from zero
            cyclic_sched_pkg::st_off: begin
                if (run_en && !ovr_q) begin
                    state_d = cyclic_sched_pkg::st_active;
                    start   = 1'b1;
                    sample  = 1'b1;
                    tmr_clr = 1'b1;
                end
            end
            // enable only looked at when the pass is done: a pulse is a glitch
            cyclic_sched_pkg::st_active: begin
                if (done) begin
                    if (ovr_q) begin
                        state_d = cyclic_sched_pkg::st_locked;
                    end else if (cont_s || pend_q || expiry) begin
                        // back to back: continuous or overrun
                        if (!run_en) begin
                            state_d = cyclic_sched_pkg::st_off;
                            cnt_clr = 1'b1;
                            tmr_clr = 1'b1;
                        end else begin
                            cnt_inc = 1'b1;
                            start   = 1'b1;
                            sample  = 1'b1;
                            tmr_clr = 1'b1;
                        end
                    end else begin
                        state_d = cyclic_sched_pkg::st_idle;
                    end
                end
            end
            // enable watched every cycle of the idle phase
            cyclic_sched_pkg::st_idle: begin
                if (!run_en) begin
                    state_d = cyclic_sched_pkg::st_off;
                    cnt_clr = 1'b1;
                    tmr_clr = 1'b1;
                end else if (expiry) begin
                    state_d = cyclic_sched_pkg::st_active;
                    cnt_inc = 1'b1;
                    start   = 1'b1;
                    sample  = 1'b1;
                end
            end
            // held until software drops the enable
            cyclic_sched_pkg::st_locked: begin
                if (!run_en) begin
                    state_d = cyclic_sched_pkg::st_off;
                    cnt_clr = 1'b1;
                    tmr_clr = 1'b1;
                end
            end
            default: begin
                state_d = cyclic_sched_pkg::st_off;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= cyclic_sched_pkg::st_off;
        end else begin
            state_q <= state_d;
        end
    end

    // cycle counter: only moves at cycle boundaries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (cnt_clr) begin
            cnt_q <= '0;
        end else if (cnt_inc) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // remembers a period that ran out before the pass finished
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (start || cnt_clr) begin
            pend_q <= 1'b0;
        end else if (expiry && state_q == cyclic_sched_pkg::st_active) begin
            pend_q <= 1'b1;
        end
    end

    // ==========================================================
    // outputs to the conversion path
    // ==========================================================
    logic step_done_q;  // step finished pulse
    logic wr_q;         // result writeback pulse

    // only steps that really ran produce results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_done_q <= 1'b0;
            wr_q        <= 1'b0;
        end else begin
            step_done_q <= send & srun;
            wr_q        <= send & srun & wb_s;
        end
    end

    assign routine_active = (state_q == cyclic_sched_pkg::st_active);
    assign step_index     = idx_q;
    assign step_done      = step_done_q;
    assign compare_strobe = step_done_q;
    assign result_write   = wr_q;
    assign step_filter    = filt_s;
    assign bal_timer_hold = bal_tim_s;
    assign bal_hold       = bal_s;

    // ==========================================================
    // checks
    // ==========================================================
    sequence start_cond;
        state_q == cyclic_sched_pkg::st_off && run_en && !ovr_q;
    endsequence

    chk_enable_start: assert property (@(posedge pclk)
        disable iff (!presetn) start_cond |=> routine_active)
        else $error("enable did not start routine");

    chk_enable_keeps: assert property (@(posedge pclk)
        disable iff (!presetn)
        start_cond |=> tmr_q == '0 && cnt_q == $past(cnt_q))
        else $error("enable start disturbed counters");

    chk_wb_gate: assert property (@(posedge pclk)
        disable iff (!presetn) result_write |-> step_done && $past(wb_s))
        else $error("writeback without enable");

    chk_wb_pass: assert property (@(posedge pclk)
        disable iff (!presetn) step_done && $past(wb_s)
        |-> result_write)
        else $error("writeback missed");

    chk_expiry_count: assert property (@(posedge pclk)
        disable iff (!presetn)
        expiry && state_q == cyclic_sched_pkg::st_idle && run_en
        |=> cnt_q == $past(cnt_q) + 8'h01 && tmr_q == '0 && idx_q == 2'b00)
        else $error("expiry did not advance cycle");

    chk_count_frozen: assert property (@(posedge pclk)
        disable iff (!presetn)
        state_q == cyclic_sched_pkg::st_idle && !expiry && run_en
        |=> cnt_q == $past(cnt_q) && tmr_q == $past(tmr_q) + 16'h0001)
        else $error("counter moved or timer stalled in idle");

    chk_skip_step: assert property (@(posedge pclk)
        disable iff (!presetn) routine_active && cur_per == '0
        |=> !step_done)
        else $error("step with zero periodicity ran");

    chk_glitch_ignore: assert property (@(posedge pclk)
        disable iff (!presetn)
        routine_active && !done && !run_en |=> routine_active)
        else $error("disable cut active phase short");

    chk_periodic_off: assert property (@(posedge pclk)
        disable iff (!presetn)
        state_q == cyclic_sched_pkg::st_idle && !run_en
        |=> state_q == cyclic_sched_pkg::st_off && cnt_q == '0
            && tmr_q == '0)
        else $error("idle disable not honoured");

    chk_override_lock: assert property (@(posedge pclk)
        disable iff (!presetn)
        done && ovr_q |=> state_q == cyclic_sched_pkg::st_locked
        ##1 !routine_active)
        else $error("routine restarted after override");

    chk_cont_restart: assert property (@(posedge pclk)
        disable iff (!presetn)
        done && cont_s && run_en && !ovr_q
        |=> routine_active && idx_q == 2'b00
            && cnt_q == $past(cnt_q) + 8'h01)
        else $error("continuous pass not restarted");

endmodule

`default_nettype wire

// ===== test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host side: apb master, request held until pready is seen
// ==========================================================
module host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic err_q;  // response of the last access
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // callers keep period fixed while running
    // mode bit goes in before enable
    // no on-demand work exists, so enable is never early
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;  // stale data would hide a missed strobe
    endtask
endmodule
`default_nettype wire

// ===== test/cyclic_conversion_scheduler_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cyclic_conversion_scheduler_tb;
    logic pclk = 1'b0, presetn = 1'b0, ovr = 1'b0, psel, pen, pwr;
    logic pready, pslverr, act, ok, rw, cs, sd, bth, bh;
    logic [2:0] sf;
    logic [1:0] si;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0, compares = 0, cyc = 0, t, t1, n_wr, n_cmp, n_sd;
    always #20 pclk = ~pclk;  // 25 MHz
    // ==========================================================
    // pulse counters and hang guard
    // ==========================================================
    always @(posedge pclk) begin
        cyc++;
        n_wr += (rw === 1'b1);
        n_sd += (sd === 1'b1);
        n_cmp += (cs === 1'b1);
        if (cyc == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    host_model host_u (.pclk(pclk), .psel(psel), .penable(pen),
        .pwrite(pwr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    cyclic_conversion_scheduler dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(pen), .pwrite(pwr), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .override_req(ovr), .routine_active(act),
        .step_index(si), .step_done(sd), .compare_strobe(cs),
        .result_write(rw), .step_filter(sf), .bal_timer_hold(bth),
        .bal_hold(bh));
    task automatic chk(input string s, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    // read the cycle counter field into q
    task automatic rd_cnt();
        host_u.xfer(1'b0, cyclic_sched_pkg::sched_stat_off, '0, q);
        q = {24'h00_0000, q[cyclic_sched_pkg::stat_cnt_lsb +: 8]};
    endtask
    // wait for the active flag to reach lvl, bounded
    task automatic wait_lvl(input logic lvl, input int lim);
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            @(posedge pclk);
            #1 ok = (act === lvl);
        end
        t = cyc;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        host_u.xfer(1'b0, 12'h000, '0, q);
        chk("ctrl_rst", 32'h0000_0000, q);
        host_u.xfer(1'b0, 12'h0FC, '0, q);
        chk("slverr", 32'h0000_0001, {31'h0, host_u.err_q});
        wr(cyclic_sched_pkg::step_period_off, 32'h0000_1111);
        wr(12'h000, 32'h0000_0005);  // periodic, writeback on
        wait_lvl(1'b1, 10);
        chk("start", 32'h1, {31'h0, ok});
        t1 = t;
        rd_cnt();
        chk("cnt_kept", 32'h0, q);
        wait_lvl(1'b0, 3000);
        wait_lvl(1'b1, 3000);
        chk("writes", 32'h4, n_wr);
        chk("period", 32'd2500, t - t1);
        rd_cnt();
        chk("cnt_inc", 32'h1, q);
        wr(12'h000, 32'h0000_0004);  // disable mid-pass
        chk("hold_act", 32'h1, {31'h0, act});
        wait_lvl(1'b0, 3000);
        wait_lvl(1'b1, 2600);
        chk("stopped", 32'h0, {31'h0, ok});
        rd_cnt();
        chk("cnt_rst", 32'h0, q);
        wr(12'h000, 32'h0000_0002);  // mode only, still off
        wait_lvl(1'b1, 50);
        chk("mode_off", 32'h0, {31'h0, ok});
        n_wr = 0;
        n_cmp = 0;
        n_sd = 0;
        wr(12'h000, 32'h0000_00CB);  // continuous, filter 1, holds on
        t1 = cyc;
        for (int i = 0; i < 3000 && n_cmp < 8; i++) @(posedge pclk);
        chk("fast", 32'h1, {31'h0, (cyc - t1) < 2500});
        chk("step_len", 32'h1, {31'h0, (cyc - t1) > 1500});
        chk("step_done", 32'h8, n_sd);
        chk("filter", 32'h1, {29'h0, sf});
        chk("holds", 32'h3, {30'h0, bth, bh});
        rd_cnt();
        chk("cnt_pass", 32'h2, q);
        chk("no_wb", 32'h0, n_wr);
        wr(12'h000, 32'h0000_0000);
        wait_lvl(1'b0, 1000);
        chk("cont_off", 32'h1, {31'h0, ok});
        wr(cyclic_sched_pkg::step_period_off, 32'h0000_0101);
        n_cmp = 0;
        wr(12'h000, 32'h0000_0001);
        wait_lvl(1'b1, 10);
        @(posedge pclk);
        ovr <= 1'b1;
        @(posedge pclk);
        ovr <= 1'b0;
        wait_lvl(1'b0, 3000);
        chk("skipped", 32'h2, n_cmp);
        wait_lvl(1'b1, 2600);
        chk("no_restart", 32'h0, {31'h0, ok});
        host_u.xfer(1'b0, cyclic_sched_pkg::sched_stat_off, '0, q);
        chk("locked", 32'h6, {29'h0, q[2:0]});
        chk("step_idx", 32'h0, {30'h0, si});
        wr(12'h000, 32'h0000_0000);
        wr(cyclic_sched_pkg::sched_stat_off, 32'h0000_0002);
        host_u.xfer(1'b0, cyclic_sched_pkg::sched_stat_off, '0, q);
        chk("unlock", 32'h0, {29'h0, q[2:0]});
        tally_and_finish();
    end
endmodule
`default_nettype wire
